// ==== rtl/acrb_bank.sv ====
// Purpose: Configuration register bank with restart control and result scaling
// Assumes: Command decoder issues one-cycle byte strobes on clk_sys
// Notes: A run of bytes is a start address plus successive strobes
module acrb_bank
    import acrb_pkg::*;
#(
    parameter logic [3:0] FACTORY_CODE = 4'h5 // Arbitrary value
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic cmd_start,
    input wire logic [4:0] cmd_addr,
    input wire logic register_write_cmd,
    input wire logic register_read_cmd,
    input wire logic [7:0] wr_byte,
    output logic [7:0] rd_byte,
    output logic rd_valid,
    input wire logic result_in_valid,
    input wire logic signed [31:0] result_in,
    output logic result_out_valid,
    output logic signed [31:0] result_out,
    output logic conv_restart,
    output acrb_setup_a_s setup_a,
    output acrb_setup_b_s setup_b,
    output acrb_corr_s corr
);
    logic [4:0] ptr;
    logic [7:0] hp_low, hp_high, zl, zm, zh, sl, sm, sh;
    logic [5:0] drop_cnt;
    logic [7:0] next_rd;
    logic [7:0] setup_a_byte;
    logic [7:0] setup_b_byte;
    logic sel_setup_a;
    logic sel_setup_b;
    logic sel_hp_low;
    logic sel_hp_high;
    logic sel_zero_low;
    logic sel_zero_mid;
    logic sel_zero_high;
    logic sel_span_low;
    logic sel_span_mid;
    logic sel_span_high;
    logic wr_setup_a;
    logic wr_setup_b;
    logic wr_hp_low;
    logic wr_hp_high;
    logic wr_zero_low;
    logic wr_zero_mid;
    logic wr_zero_high;
    logic wr_span_low;
    logic wr_span_mid;
    logic wr_span_high;

    // Address pointer advances on each byte of a run
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ptr <= ADDR_PART_CODE;
        end else if (cmd_start) begin
            ptr <= cmd_addr;
        end else if (register_write_cmd || register_read_cmd) begin
            ptr <= ptr + 5'h01;
        end
    end

    // Decode of the pointer; identity and unmapped addresses select nothing
    always_comb begin
        sel_setup_a = 1'b0;
        sel_setup_b = 1'b0;
        sel_hp_low = 1'b0;
        sel_hp_high = 1'b0;
        sel_zero_low = 1'b0;
        sel_zero_mid = 1'b0;
        sel_zero_high = 1'b0;
        sel_span_low = 1'b0;
        sel_span_mid = 1'b0;
        sel_span_high = 1'b0;
        if (ptr == ADDR_SETUP_A) begin
            sel_setup_a = 1'b1;
        end else if (ptr == ADDR_SETUP_B) begin
            sel_setup_b = 1'b1;
        end else if (ptr == ADDR_HP_LOW) begin
            sel_hp_low = 1'b1;
        end else if (ptr == ADDR_HP_HIGH) begin
            sel_hp_high = 1'b1;
        end else if (ptr == ADDR_ZERO_LOW) begin
            sel_zero_low = 1'b1;
        end else if (ptr == ADDR_ZERO_MID) begin
            sel_zero_mid = 1'b1;
        end else if (ptr == ADDR_ZERO_HIGH) begin
            sel_zero_high = 1'b1;
        end else if (ptr == ADDR_SPAN_LOW) begin
            sel_span_low = 1'b1;
        end else if (ptr == ADDR_SPAN_MID) begin
            sel_span_mid = 1'b1;
        end else if (ptr == ADDR_SPAN_HIGH) begin
            sel_span_high = 1'b1;
        end
    end

    // No enable exists for the identity byte, so writes there change no register but still restart conversion
    always_comb begin
        wr_setup_a = register_write_cmd && sel_setup_a;
        wr_setup_b = register_write_cmd && sel_setup_b;
        wr_hp_low = register_write_cmd && sel_hp_low;
        wr_hp_high = register_write_cmd && sel_hp_high;
        wr_zero_low = register_write_cmd && sel_zero_low;
        wr_zero_mid = register_write_cmd && sel_zero_mid;
        wr_zero_high = register_write_cmd && sel_zero_high;
        wr_span_low = register_write_cmd && sel_span_low;
        wr_span_mid = register_write_cmd && sel_span_mid;
        wr_span_high = register_write_cmd && sel_span_high;
    end

    assign setup_a = acrb_setup_a_s'(setup_a_byte);
    assign setup_b = acrb_setup_b_s'(setup_b_byte);

    acrb_byte_reg #(
        .RESET_VALUE(RST_SETUP_A)
    ) setup_a_reg (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .load(wr_setup_a),
        .d(wr_byte),
        .q(setup_a_byte)
    );

    acrb_byte_reg #(
        .RESET_VALUE(RST_SETUP_B),
        .WRITE_MASK(SETUP_B_WMASK)
    ) setup_b_reg (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .load(wr_setup_b),
        .d(wr_byte),
        .q(setup_b_byte)
    );

    acrb_byte_reg #(
        .RESET_VALUE(RST_HP_LOW)
    ) hp_low_reg (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .load(wr_hp_low),
        .d(wr_byte),
        .q(hp_low)
    );

    acrb_byte_reg #(
        .RESET_VALUE(RST_HP_HIGH)
    ) hp_high_reg (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .load(wr_hp_high),
        .d(wr_byte),
        .q(hp_high)
    );

    acrb_byte_reg #(
        .RESET_VALUE(RST_ZERO)
    ) zero_low_reg (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .load(wr_zero_low),
        .d(wr_byte),
        .q(zl)
    );

    acrb_byte_reg #(
        .RESET_VALUE(RST_ZERO)
    ) zero_mid_reg (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .load(wr_zero_mid),
        .d(wr_byte),
        .q(zm)
    );

    acrb_byte_reg #(
        .RESET_VALUE(RST_ZERO)
    ) zero_high_reg (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .load(wr_zero_high),
        .d(wr_byte),
        .q(zh)
    );

    acrb_byte_reg #(
        .RESET_VALUE(RST_SPAN_LOW)
    ) span_low_reg (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .load(wr_span_low),
        .d(wr_byte),
        .q(sl)
    );

    acrb_byte_reg #(
        .RESET_VALUE(RST_SPAN_MID)
    ) span_mid_reg (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .load(wr_span_mid),
        .d(wr_byte),
        .q(sm)
    );

    acrb_byte_reg #(
        .RESET_VALUE(RST_SPAN_HIGH)
    ) span_high_reg (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .load(wr_span_high),
        .d(wr_byte),
        .q(sh)
    );

    always_comb begin
        corr.highpass_corner = {hp_high, hp_low};
        corr.zero_correction = {zh, zm, zl};
        corr.span_correction = {sh, sm, sl};
    end

    always_comb begin
        next_rd = 8'h00;
        if (ptr == ADDR_PART_CODE) begin
            next_rd = {FACTORY_CODE, PART_LOW_ZERO};
        end else if (ptr == ADDR_SETUP_A) begin
            next_rd = setup_a;
        end else if (ptr == ADDR_SETUP_B) begin
            next_rd = setup_b;
        end else if (ptr == ADDR_HP_LOW) begin
            next_rd = hp_low;
        end else if (ptr == ADDR_HP_HIGH) begin
            next_rd = hp_high;
        end else if (ptr == ADDR_ZERO_LOW) begin
            next_rd = zl;
        end else if (ptr == ADDR_ZERO_MID) begin
            next_rd = zm;
        end else if (ptr == ADDR_ZERO_HIGH) begin
            next_rd = zh;
        end else if (ptr == ADDR_SPAN_LOW) begin
            next_rd = sl;
        end else if (ptr == ADDR_SPAN_MID) begin
            next_rd = sm;
        end else if (ptr == ADDR_SPAN_HIGH) begin
            next_rd = sh;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rd_byte <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= register_read_cmd;
            if (register_read_cmd) begin
                rd_byte <= next_rd;
            end
        end
    end

    // Restart pulse and drop counter after each write
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            conv_restart <= 1'b0;
            drop_cnt <= 6'h00;
        end else begin
            conv_restart <= register_write_cmd;
            if (register_write_cmd) begin
                drop_cnt <= RESTART_DROP;
            end else if (result_in_valid && drop_cnt != 6'h00) begin
                drop_cnt <= drop_cnt - 6'h01;
            end
        end
    end

    logic signed [32:0] diff;
    logic signed [57:0] prod;
    always_comb begin
        // Zero correction is two's complement, so it is sign-extended
        diff = 33'(result_in) - 33'(signed'({corr.zero_correction, 8'h00}));
        prod = 58'(diff) * 58'($signed({1'b0, corr.span_correction}));
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            result_out <= 32'h0000_0000;
            result_out_valid <= 1'b0;
        end else begin
            result_out_valid <= result_in_valid && drop_cnt == 6'h00 && !register_write_cmd;
            if (result_in_valid) begin
                result_out <= 32'(prod >>> SPAN_UNITY_SHIFT);
            end
        end
    end
endmodule

// One configuration byte with its own reset value and writable-bit mask
module acrb_byte_reg #(
    parameter logic [7:0] RESET_VALUE = 8'h00,
    parameter logic [7:0] WRITE_MASK = 8'hFF
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic [7:0] d,
    output logic [7:0] q
);
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            q <= RESET_VALUE;
        end else if (load) begin
            q <= d & WRITE_MASK;
        end
    end
endmodule

// ==== rtl/acrb_pkg.sv ====
// Purpose: Constants and types for the converter configuration register bank
// Assumes: Byte-wide registers reached by register read/write command ports
// Notes: Field positions and reset values shared by bank and bench
// Overview of operation
// - Registers reached only by read/write commands, single or consecutive byte runs.
// - Any register write restarts conversion; 63 results are dropped afterwards.
// - Setup A bit 7 selects pulse (0, default) or continuous (1) sync.
// - Setup A bit 6 is resolution mode flag, reset value 1.
// - Setup A bits 5:3 select output rate, default code 010.
// - Setup A bit 2 selects linear (0, default) or minimum phase FIR.
// - Setup A bits 1:0 select filter chain, default sinc plus low-pass.
// - Setup B bits 6:4 route inputs, default pair one.
// - Setup B bit 3 enables amplifier chopping, reset value 1.
// - Setup B bits 2:0 set gain power of two, default code 000.
// - High-pass corner is low byte 03h and high byte 04h combined.
// - Zero correction is bytes 05h low, 06h middle, 07h high.
// - Result is input minus 256 times zero correction, times span correction over 400000h.
package acrb_pkg;
    localparam logic [4:0] ADDR_PART_CODE = 5'h00;
    localparam logic [4:0] ADDR_SETUP_A = 5'h01;
    localparam logic [4:0] ADDR_SETUP_B = 5'h02;
    localparam logic [4:0] ADDR_HP_LOW = 5'h03;
    localparam logic [4:0] ADDR_HP_HIGH = 5'h04;
    localparam logic [4:0] ADDR_ZERO_LOW = 5'h05;
    localparam logic [4:0] ADDR_ZERO_MID = 5'h06;
    localparam logic [4:0] ADDR_ZERO_HIGH = 5'h07;
    localparam logic [4:0] ADDR_SPAN_LOW = 5'h08;
    localparam logic [4:0] ADDR_SPAN_MID = 5'h09;
    localparam logic [4:0] ADDR_SPAN_HIGH = 5'h0A;
    localparam logic [4:0] ADDR_LAST = 5'h0A;

    localparam logic [7:0] RST_SETUP_A = 8'h52;
    localparam logic [7:0] RST_SETUP_B = 8'h08;
    localparam logic [7:0] RST_HP_LOW = 8'h32;
    localparam logic [7:0] RST_HP_HIGH = 8'h03;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_SPAN_LOW = 8'h00;
    localparam logic [7:0] RST_SPAN_MID = 8'h00;
    localparam logic [7:0] RST_SPAN_HIGH = 8'h40;
    localparam logic [7:0] SETUP_B_WMASK = 8'h7F;
    localparam logic [3:0] PART_LOW_ZERO = 4'h0;

    // Conversions lost after a register write
    localparam logic [5:0] RESTART_DROP = 6'h3F;
    // Unity gain point of the span correction
    localparam int SPAN_UNITY_SHIFT = 22;

    typedef enum logic {SYNC_PULSE, SYNC_CONTINUOUS} acrb_sync_e;

    typedef struct packed {
        acrb_sync_e sync_mode;
        logic high_res;
        logic [2:0] output_rate_select;
        logic min_phase;
        logic [1:0] filter_chain_select;
    } acrb_setup_a_s;

    typedef struct packed {
        logic rsvd;
        logic [2:0] input_selector;
        logic amp_swap_enable;
        logic [2:0] amp_gain_select;
    } acrb_setup_b_s;

    typedef struct packed {
        logic [15:0] highpass_corner;
        logic signed [23:0] zero_correction;
        logic [23:0] span_correction;
    } acrb_corr_s;
endpackage

// ==== verif/acrb_chk.sv ====
// Purpose: Port-level checks for acrb_bank
// Assumes: Only the bank ports are visible
// Notes: Bound to every acrb_bank
module acrb_chk
    import acrb_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic register_write_cmd,
    input wire logic register_read_cmd,
    input wire logic rd_valid,
    input wire logic result_in_valid,
    input wire logic result_out_valid,
    input wire logic conv_restart,
    input wire acrb_setup_a_s setup_a,
    input wire acrb_setup_b_s setup_b,
    input wire acrb_corr_s corr
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    a_restart_pulse: assert property (register_write_cmd |=> conv_restart)
        else $error("restart missing after write");
    a_restart_only: assert property (!register_write_cmd |=> !conv_restart)
        else $error("restart without write");
    a_drop_on_write: assert property (conv_restart ##1 result_in_valid |=> !result_out_valid)
        else $error("result not dropped after write");
    a_read_answer: assert property (register_read_cmd |=> rd_valid)
        else $error("read not answered");
    a_reset_setup: assert property ($fell(sys_rst) |-> {setup_a, setup_b} == 16'h5208)
        else $error("setup reset value wrong");
    a_reset_corr: assert property ($fell(sys_rst) |-> corr == 64'h0332_000000_400000)
        else $error("correction reset value wrong");
    a_setup_hold: assert property (!$past(register_write_cmd) |-> $stable({setup_a, setup_b}))
        else $error("setup changed without write");
    a_out_source: assert property (result_out_valid |-> $past(result_in_valid))
        else $error("result without input");
    cover property (conv_restart ##1 result_in_valid);
    cover property (rd_valid);
    cover property (result_out_valid);
endmodule
bind acrb_bank acrb_chk acrb_chk_i (.clk_sys, .sys_rst, .register_write_cmd, .register_read_cmd,
    .rd_valid, .result_in_valid, .result_out_valid, .conv_restart, .setup_a, .setup_b, .corr);

// ==== verif/acrb_host.sv ====
// Purpose: Host model issuing register commands
// Assumes: Changes land on the falling edge
// Notes: Idle data and address lines show the inverse of their last value
module acrb_host (
    input wire logic clk_sys,
    output logic cmd_start,
    output logic [4:0] cmd_addr,
    output logic register_write_cmd,
    output logic register_read_cmd,
    output logic [7:0] wr_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {cmd_start, register_write_cmd, register_read_cmd, cmd_addr, wr_byte} = 16'h0000;
    end
    task automatic send(input logic s, w, r, input logic [4:0] a, input logic [7:0] b);
        @(negedge clk_sys);
        cmd_start = s;
        register_write_cmd = w;
        register_read_cmd = r;
        cmd_addr = s ? a : ~cmd_addr;
        wr_byte = w ? b : ~wr_byte;
    endtask
endmodule

// ==== verif/acrb_bank_bench.sv ====
// Purpose: Self-checking bench for acrb_bank
// Assumes: Host model drives commands on the falling edge
// Notes: Expected values pass through queues to a monitor
module acrb_bank_bench
    import acrb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0;
    logic sys_rst = 1;
    logic result_in_valid = 0;
    logic signed [31:0] result_in = 0;
    logic cmd_start, register_write_cmd, register_read_cmd, rd_valid, result_out_valid, conv_restart;
    logic [4:0] cmd_addr;
    logic [7:0] wr_byte, rd_byte, v;
    logic signed [31:0] result_out, x;
    logic [7:0] e[11] = '{8'hA0, 8'h52, 8'h08, 8'h32, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40};
    logic [7:0] exp_q[$];
    logic [31:0] res_q[$];
    int miscompares = 0;
    int n_compared = 0;
    acrb_setup_a_s setup_a;
    acrb_setup_b_s setup_b;
    acrb_corr_s corr;
    always #5 clk_sys = ~clk_sys;
    acrb_bank #(.FACTORY_CODE(4'hA)) acrb_bank_i (.clk_sys, .sys_rst, .cmd_start, .cmd_addr,
        .register_write_cmd, .register_read_cmd, .wr_byte, .rd_byte, .rd_valid, .result_in_valid,
        .result_in, .result_out_valid, .result_out, .conv_restart, .setup_a, .setup_b, .corr);
    acrb_host acrb_host_i (.clk_sys, .cmd_start, .cmd_addr, .register_write_cmd,
        .register_read_cmd, .wr_byte);
    task automatic check(input logic [31:0] got, input logic [31:0] want);
        n_compared++;
        if (got !== want) begin
            miscompares++;
            $display("[FAIL] %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic give_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Reads every register as one run, then one unmapped address
    task automatic read_all;
        acrb_host_i.send(1, 0, 0, 5'h00, 8'h00);
        foreach (e[i]) begin
            exp_q.push_back(e[i]);
            acrb_host_i.send(0, 0, 1, 5'h00, 8'h00);
        end
        acrb_host_i.send(1, 0, 0, 5'h1F, 8'h00);
        exp_q.push_back(8'h00);
        acrb_host_i.send(0, 0, 1, 5'h00, 8'h00);
        acrb_host_i.send(0, 0, 0, 5'h00, 8'h00);
    endtask
    always @(posedge clk_sys) begin
        if (rd_valid) check({24'h000000, rd_byte}, {24'h000000, exp_q.pop_front()});
        if (result_out_valid) check(result_out, res_q.pop_front());
    end
    initial begin
        #100us;
        miscompares++;
        give_verdict();
    end
    initial begin
        x = $urandom(72);
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys) sys_rst = 0;
        read_all();
        acrb_host_i.send(1, 0, 0, 5'h01, 8'h00);
        for (int i = 1; i < 11; i++) begin
            v = $urandom;
            if (i == 1) v[5:3] = 3'($urandom % 5);
            if (i == 2) v = {1'b0, 3'($urandom % 5), v[3], 3'($urandom % 7)};
            if (i > 4) v = (i == 5) ? 8'h01 : (i == 10) ? 8'h20 : 8'h00;
            e[i] = v;
            acrb_host_i.send(0, 1, 0, 5'h00, v);
        end
        acrb_host_i.send(0, 0, 0, 5'h00, 8'h00);
        check({24'h000000, setup_a}, {24'h000000, e[1]});
        check({24'h000000, setup_b}, {24'h000000, e[2]});
        check({16'h0000, corr.highpass_corner}, {16'h0000, e[4], e[3]});
        check({8'h00, corr.zero_correction}, 32'h00000001);
        check({8'h00, corr.span_correction}, 32'h00200000);
        for (int i = 0; i < 70; i++) begin
            x = $urandom;
            x = x >>> 2;
            if (i >= 63) res_q.push_back(32'((longint'(x) - 256) * 2097152 >>> 22));
            @(negedge clk_sys);
            result_in_valid = 1;
            result_in = x;
        end
        @(negedge clk_sys) result_in_valid = 0;
        read_all();
        repeat (4) @(posedge clk_sys);
        check(32'(res_q.size() + exp_q.size()), 32'h00000000);
        // Reset between runs, once traffic is idle, must restore every reset value and pass the next result unchanged
        @(negedge clk_sys) sys_rst = 1;
        repeat (2) @(negedge clk_sys);
        sys_rst = 0;
        e = '{8'hA0, 8'h52, 8'h08, 8'h32, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40};
        x = $urandom;
        res_q.push_back(x);
        @(negedge clk_sys);
        result_in_valid = 1;
        result_in = x;
        @(negedge clk_sys) result_in_valid = 0;
        read_all();
        repeat (4) @(posedge clk_sys);
        check(32'(res_q.size() + exp_q.size()), 32'h00000000);
        give_verdict();
    end
endmodule
